/* File: pio_pkg.sv */
// Purpose: Shared constants for the three-port parallel I/O block.
// Assumes: APB slave with 32-bit data, one word per register.
// Notes: Register indices are multiplied by four to form byte addresses.
package pio_pkg;

	localparam int PIO_ADDR_W = 8;
	localparam int PIO_DATA_W = 32;
	localparam int PIO_P0_W = 8;
	localparam int PIO_P1_W = 8;
	localparam int PIO_P2_W = 3;
	localparam int PIO_PIN_W = PIO_P0_W + PIO_P1_W + PIO_P2_W;
	localparam int PIO_IRQ_W = 5;

	// Register indices; the byte address is four times the index.
	localparam logic [5:0] PIO_IDX_P0_LATCH = 6'h00;
	localparam logic [5:0] PIO_IDX_P1_LATCH = 6'h01;
	localparam logic [5:0] PIO_IDX_P2_LATCH = 6'h02;
	localparam logic [5:0] PIO_IDX_P0_TYPE = 6'h08;
	localparam logic [5:0] PIO_IDX_P1_DIR = 6'h09;
	localparam logic [5:0] PIO_IDX_P0_PINS = 6'h0B;
	localparam logic [5:0] PIO_IDX_P2_PINS = 6'h0C;
	localparam logic [5:0] PIO_IDX_IRQ_STAT = 6'h10;
	localparam logic [5:0] PIO_IDX_IRQ_MASK = 6'h11;
	localparam logic [5:0] PIO_IDX_CTRL = 6'h12;

	// Reset values.
	localparam logic [7:0] PIO_RST_P0_LATCH = 8'hFF;
	localparam logic [7:0] PIO_RST_P0_TYPE = 8'h00;
	localparam logic [7:0] PIO_RST_P1_LATCH = 8'h00;
	localparam logic [7:0] PIO_RST_P1_DIR = 8'h00;
	localparam logic [2:0] PIO_RST_P2_LATCH = 3'h7;
	localparam logic [4:0] PIO_RST_IRQ = 5'h00;
	localparam logic [1:0] PIO_RST_CTRL = 2'h0;

	// Control register fields.
	localparam int PIO_CTRL_DUAL_CLK = 0;
	localparam int PIO_CTRL_STOP = 1;

	// Interrupt status bit positions and their source pins.
	localparam int PIO_IRQ_P20 = 0;
	localparam int PIO_IRQ_P00 = 1;
	localparam int PIO_IRQ_P03 = 2;
	localparam int PIO_IRQ_P07 = 3;
	localparam int PIO_IRQ_P15 = 4;

	// Positions inside the flattened synchroniser vector.
	localparam int PIO_POS_P1 = PIO_P0_W;
	localparam int PIO_POS_P2 = PIO_P0_W + PIO_P1_W;

endpackage : pio_pkg

/* File: pio_ports.sv */
// Purpose: Ports 0, 1 and 2 of a parallel I/O block behind an APB slave.
// Assumes: One clock; pins arrive asynchronously and pass three flops.
// Notes: A read samples pins in the setup cycle, a write lands at the
// access edge, mirroring the early read and later write of a port cycle.
`timescale 1ns/1ps

module pio_ports
	import pio_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [PIO_ADDR_W-1:0] i_paddr,
	input wire logic [PIO_DATA_W-1:0] i_pwdata,
	output logic [PIO_DATA_W-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [PIO_P0_W-1:0] i_p0_pin,
	output logic [PIO_P0_W-1:0] o_p0_pin,
	output logic [PIO_P0_W-1:0] o_p0_pin_oe,
	input wire logic [PIO_P0_W-1:0] i_p0_periph_out,
	input wire logic [PIO_P1_W-1:0] i_p1_pin,
	output logic [PIO_P1_W-1:0] o_p1_pin,
	output logic [PIO_P1_W-1:0] o_p1_pin_oe,
	input wire logic [PIO_P1_W-1:0] i_p1_periph_out,
	input wire logic [PIO_P2_W-1:0] i_p2_pin,
	output logic [PIO_P2_W-1:0] o_p2_pin,
	output logic [PIO_P2_W-1:0] o_p2_pin_oe,
	output logic [PIO_P0_W-1:0] o_p0_in,
	output logic [PIO_P1_W-1:0] o_p1_in,
	output logic [PIO_P2_W-1:0] o_p2_in,
	output logic o_slow_crystal_en,
	output logic o_stop_mode,
	output logic o_irq
);

	// Register state.
	logic [7:0] p0_latch_reg;
	logic [7:0] p0_type_reg;
	logic [7:0] p1_latch_reg;
	logic [7:0] p1_dir_reg;
	logic [2:0] p2_latch_reg;
	logic [4:0] irq_stat_reg;
	logic [4:0] irq_mask_reg;
	logic [1:0] ctrl_reg;
	logic [PIO_DATA_W-1:0] prdata_reg;
	logic [PIO_DATA_W-1:0] prdata_next;

	// Pin synchronisers and filtered levels.
	logic [PIO_PIN_W-1:0] sync1_reg;
	logic [PIO_PIN_W-1:0] sync2_reg;
	logic [PIO_PIN_W-1:0] sync3_reg;
	logic [PIO_PIN_W-1:0] pin_reg;
	logic [PIO_PIN_W-1:0] pin_next;
	logic [PIO_PIN_W-1:0] pin_prev_reg;
	wire [PIO_PIN_W-1:0] pin_raw = {i_p2_pin, i_p1_pin, i_p0_pin};

	// Bus decode.
	wire [5:0] idx = i_paddr[PIO_ADDR_W-1:2];
	wire setup_ph = i_psel && !i_penable;
	wire access_ph = i_psel && i_penable;
	wire wr_en = access_ph && i_pwrite;
	wire hit_p0_latch = (idx == PIO_IDX_P0_LATCH);
	wire hit_p1_latch = (idx == PIO_IDX_P1_LATCH);
	wire hit_p2_latch = (idx == PIO_IDX_P2_LATCH);
	wire hit_p0_type = (idx == PIO_IDX_P0_TYPE);
	wire hit_p1_dir = (idx == PIO_IDX_P1_DIR);
	wire hit_p0_pins = (idx == PIO_IDX_P0_PINS);
	wire hit_p2_pins = (idx == PIO_IDX_P2_PINS);
	wire hit_stat = (idx == PIO_IDX_IRQ_STAT);
	wire hit_mask = (idx == PIO_IDX_IRQ_MASK);
	wire hit_ctrl = (idx == PIO_IDX_CTRL);
	wire aligned = (i_paddr[1:0] == 2'b00);
	wire hit_any = aligned && (hit_p0_latch || hit_p1_latch ||
		hit_p2_latch || hit_p0_type || hit_p1_dir || hit_p0_pins ||
		hit_p2_pins || hit_stat || hit_mask || hit_ctrl);
	// Pin level registers are read-only, so a write to them is refused.
	wire ro_write = i_pwrite && (hit_p0_pins || hit_p2_pins);
	wire bad = !hit_any || ro_write;
	wire wr_ok = wr_en && !bad;

	// Filtered pin levels per port.
	wire [7:0] p0_pins = pin_reg[PIO_POS_P1-1:0];
	wire [7:0] p1_pins = pin_reg[PIO_POS_P2-1:PIO_POS_P1];
	wire [2:0] p2_pins = pin_reg[PIO_PIN_W-1:PIO_POS_P2];
	wire dual_clk = ctrl_reg[PIO_CTRL_DUAL_CLK];
	wire stop_mode = ctrl_reg[PIO_CTRL_STOP];

	// Effective output values.
	wire [7:0] p0_eff = p0_latch_reg & i_p0_periph_out;
	wire [7:0] p1_eff = p1_latch_reg & i_p1_periph_out;
	wire [2:0] p2_eff = p2_latch_reg;

	// Port-1 data read mixes latch and live pins per direction bit.
	wire [7:0] p1_read = (p1_latch_reg & p1_dir_reg) |
		(p1_pins & ~p1_dir_reg);

	// Read data is formed in the setup cycle so pins are sampled early.
	wire [PIO_DATA_W-1:0] rd_p0_latch = {24'h00_0000, p0_latch_reg};
	wire [PIO_DATA_W-1:0] rd_p1_latch = {24'h00_0000, p1_read};
	wire [PIO_DATA_W-1:0] rd_p2_latch = {29'h0000_0000, p2_latch_reg};
	wire [PIO_DATA_W-1:0] rd_p0_type = {24'h00_0000, p0_type_reg};
	wire [PIO_DATA_W-1:0] rd_p1_dir = {24'h00_0000, p1_dir_reg};
	wire [PIO_DATA_W-1:0] rd_p0_pins = {24'h00_0000, p0_pins};
	wire [PIO_DATA_W-1:0] rd_p2_pins = {29'h0000_0000, p2_pins};
	wire [PIO_DATA_W-1:0] rd_stat = {27'h000_0000, irq_stat_reg};
	wire [PIO_DATA_W-1:0] rd_mask = {27'h000_0000, irq_mask_reg};
	wire [PIO_DATA_W-1:0] rd_ctrl = {30'h0000_0000, ctrl_reg};

	always_comb begin
		if (!aligned) begin
			prdata_next = '0;
		end else if (hit_p0_latch) begin
			prdata_next = rd_p0_latch;
		end else if (hit_p1_latch) begin
			prdata_next = rd_p1_latch;
		end else if (hit_p2_latch) begin
			prdata_next = rd_p2_latch;
		end else if (hit_p0_type) begin
			prdata_next = rd_p0_type;
		end else if (hit_p1_dir) begin
			prdata_next = rd_p1_dir;
		end else if (hit_p0_pins) begin
			prdata_next = rd_p0_pins;
		end else if (hit_p2_pins) begin
			prdata_next = rd_p2_pins;
		end else if (hit_stat) begin
			prdata_next = rd_stat;
		end else if (hit_mask) begin
			prdata_next = rd_mask;
		end else if (hit_ctrl) begin
			prdata_next = rd_ctrl;
		end else begin
			prdata_next = '0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			prdata_reg <= '0;
		end else if (setup_ph && !i_pwrite) begin
			prdata_reg <= prdata_next;
		end
	end

	// Three-flop synchroniser; a change counts once stages two and three
	// agree, which also filters a single-cycle glitch.
	assign pin_next = (sync2_reg & sync3_reg) |
		(pin_reg & (sync2_reg ^ sync3_reg));

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			pin_reg <= '0;
			pin_prev_reg <= '0;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			pin_reg <= pin_next;
			pin_prev_reg <= pin_reg;
		end
	end

	// Port-0 latch and output type.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			p0_latch_reg <= PIO_RST_P0_LATCH;
			p0_type_reg <= PIO_RST_P0_TYPE;
		end else if (wr_ok && hit_p0_latch) begin
			p0_latch_reg <= i_pwdata[7:0];
		end else if (wr_ok && hit_p0_type) begin
			p0_type_reg <= i_pwdata[7:0];
		end
	end

	// Port-1 latch and direction. A write of a read-back value stores the
	// pin level of every input bit into its latch; software mixing
	// directions must expect that.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			p1_latch_reg <= PIO_RST_P1_LATCH;
			p1_dir_reg <= PIO_RST_P1_DIR;
		end else if (wr_ok && hit_p1_latch) begin
			p1_latch_reg <= i_pwdata[7:0];
		end else if (wr_ok && hit_p1_dir) begin
			p1_dir_reg <= i_pwdata[7:0];
		end
	end

	// Port-2 latch and control.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			p2_latch_reg <= PIO_RST_P2_LATCH;
			ctrl_reg <= PIO_RST_CTRL;
		end else if (wr_ok && hit_p2_latch) begin
			p2_latch_reg <= i_pwdata[2:0];
		end else if (wr_ok && hit_ctrl) begin
			ctrl_reg <= i_pwdata[1:0];
		end
	end

	// Interrupt sources are falling edges of the filtered pin levels. On
	// port-2 bit 0 the pin follows the driven output too, so a falling
	// output still sets the latch.
	wire [PIO_PIN_W-1:0] fall = pin_prev_reg & ~pin_reg;
	wire [4:0] irq_set;
	assign irq_set[PIO_IRQ_P20] = fall[PIO_POS_P2];
	assign irq_set[PIO_IRQ_P00] = fall[0];
	assign irq_set[PIO_IRQ_P03] = fall[3];
	assign irq_set[PIO_IRQ_P07] = fall[7];
	assign irq_set[PIO_IRQ_P15] = fall[PIO_POS_P1 + 5];
	wire [4:0] irq_clr = (wr_ok && hit_stat) ? i_pwdata[4:0] : 5'h00;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_stat_reg <= PIO_RST_IRQ;
			irq_mask_reg <= PIO_RST_IRQ;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			if (wr_ok && hit_mask) begin
				irq_mask_reg <= i_pwdata[4:0];
			end
		end
	end

	// Port 0: push-pull drives both levels, open drain only sinks.
	assign o_p0_pin = p0_eff & p0_type_reg;
	assign o_p0_pin_oe = p0_type_reg | ~p0_eff;

	// Port 1: direction bit enables the driver.
	assign o_p1_pin = p1_eff;
	assign o_p1_pin_oe = p1_dir_reg;

	// Port 2 is sink-only; crystal pins are released in dual-clock mode, the stop-release pin in stop mode.
	wire [2:0] p2_keep;
	assign p2_keep[0] = !stop_mode;
	assign p2_keep[1] = !dual_clk;
	assign p2_keep[2] = !dual_clk;
	assign o_p2_pin = 3'h0;
	assign o_p2_pin_oe = ~p2_eff & p2_keep;

	assign o_p0_in = p0_pins;
	assign o_p1_in = p1_pins;
	assign o_p2_in = p2_pins;
	assign o_slow_crystal_en = dual_clk;
	assign o_stop_mode = stop_mode;
	assign o_irq = |(irq_stat_reg & irq_mask_reg);
	assign o_prdata = prdata_reg;
	assign o_pready = 1'b1;
	assign o_pslverr = access_ph && bad;

	// Checks.
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	a_p0_write_lands: assert property (
		wr_ok && hit_p0_latch |=> p0_latch_reg == $past(i_pwdata[7:0]))
		else $error("Port-0 latch missed a write.");

	a_p1_read_mix: assert property (
		setup_ph && !i_pwrite && aligned && hit_p1_latch |=>
		o_prdata[7:0] == (($past(p1_latch_reg) & $past(p1_dir_reg)) |
		($past(p1_pins) & ~$past(p1_dir_reg))))
		else $error("Port-1 read did not mix latch and pins.");

	a_p0_pin_sample: assert property (
		setup_ph && !i_pwrite && aligned && hit_p0_pins |=>
		o_prdata[7:0] == $past(p0_pins))
		else $error("Port-0 pin read not sampled at setup.");

	a_p0_push_pull: assert property (
		&p0_type_reg |-> o_p0_pin_oe == 8'hFF && o_p0_pin == p0_eff)
		else $error("Push-pull port-0 not driving both levels.");

	a_p0_open_drain: assert property (
		p0_type_reg == 8'h00 |-> o_p0_pin == 8'h00 &&
		o_p0_pin_oe == ~(p0_latch_reg & i_p0_periph_out))
		else $error("Open-drain port-0 drive wrong.");

	a_p2_stop_release: assert property (
		stop_mode |-> !o_p2_pin_oe[0])
		else $error("Stop-release pin driven in stop mode.");

	a_p2_crystal: assert property (
		dual_clk |-> o_p2_pin_oe[2:1] == 2'b00)
		else $error("Crystal pins driven in dual-clock mode.");

	a_p20_fall_irq: assert property (
		$fell(p2_pins[0]) |=> irq_stat_reg[PIO_IRQ_P20])
		else $error("Port-2 bit 0 edge lost.");

	a_p1_periph_and: assert property (
		o_p1_pin == (p1_latch_reg & i_p1_periph_out))
		else $error("Port-1 output not gated by latch.");

	a_stat_set_wins: assert property (
		irq_set != 5'h00 |=> (irq_stat_reg & $past(irq_set)) ==
		$past(irq_set))
		else $error("Interrupt event lost against clear.");

	a_irq_level: assert property (
		$rose(o_irq) |-> (($past(irq_set) & $past(irq_mask_reg)) != 5'h00) ||
		($past(wr_ok) && $past(hit_mask)))
		else $error("Interrupt rose without an event or mask write.");

	a_ro_refused: assert property (
		wr_en && hit_p0_pins |-> o_pslverr ##1 $stable(p0_latch_reg))
		else $error("Write to pin register not refused.");

	a_p1_write_lands: assert property (
		wr_ok && hit_p1_latch |=> p1_latch_reg == $past(i_pwdata[7:0]))
		else $error("Port-1 latch missed a write.");

	a_p2_write_lands: assert property (
		wr_ok && hit_p2_latch |=> p2_latch_reg == $past(i_pwdata[2:0]))
		else $error("Port-2 latch missed a write.");

	a_p2_sink_only: assert property (
		(o_p2_pin_oe & p2_latch_reg) == 3'h0 && o_p2_pin == 3'h0)
		else $error("Port-2 pin driven while its latch is one.");

	a_stat_clear: assert property (
		wr_ok && hit_stat && irq_set == 5'h00 |=>
		(irq_stat_reg & $past(i_pwdata[4:0])) == 5'h00)
		else $error("Status bit not cleared by a one.");

	a_refused_keep: assert property (
		wr_en && bad |=> $stable(p0_latch_reg) && $stable(p0_type_reg) &&
		$stable(p1_latch_reg) && $stable(p1_dir_reg) && $stable(ctrl_reg))
		else $error("Refused write changed a register.");

	a_read_keeps: assert property (
		access_ph && !i_pwrite |=> $stable(p0_latch_reg) &&
		$stable(p1_latch_reg) && $stable(p2_latch_reg))
		else $error("A read changed an output latch.");

	a_p2_pin_sample: assert property (
		setup_ph && !i_pwrite && aligned && hit_p2_pins |=>
		o_prdata[2:0] == $past(p2_pins) && o_prdata[31:3] == 29'h0000_0000)
		else $error("Port-2 pin read wrong.");

	a_p0_latch_read: assert property (
		setup_ph && !i_pwrite && aligned && hit_p0_latch |=>
		o_prdata[7:0] == $past(p0_latch_reg))
		else $error("Port-0 latch read wrong.");

	a_pin_agree: assert property (
		((pin_reg ^ $past(pin_reg)) &
		($past(sync2_reg) ^ $past(sync3_reg))) == {PIO_PIN_W{1'b0}})
		else $error("Pin level changed without agreeing stages.");

endmodule : pio_ports

/* File: pio_pins_model.sv */
// Purpose: Pin model facing the three ports of the parallel I/O block.
// Assumes: Released port 0 and port 2 lines rest at the outside level.
// Notes: The outside level stands in for pull-ups and other drivers.
`timescale 1ns/1ps

module pio_pins_model
	import pio_pkg::*;
(
	input wire logic [PIO_P0_W-1:0] i_p0_drv,
	input wire logic [PIO_P0_W-1:0] i_p0_oe,
	input wire logic [PIO_P0_W-1:0] i_p0_ext,
	input wire logic [PIO_P1_W-1:0] i_p1_drv,
	input wire logic [PIO_P1_W-1:0] i_p1_oe,
	input wire logic [PIO_P1_W-1:0] i_p1_ext,
	input wire logic [PIO_P2_W-1:0] i_p2_oe,
	input wire logic [PIO_P2_W-1:0] i_p2_ext,
	output logic [PIO_P0_W-1:0] o_p0_lvl,
	output logic [PIO_P1_W-1:0] o_p1_lvl,
	output logic [PIO_P2_W-1:0] o_p2_lvl
);
	// A driven bit wins; a released bit shows the outside level.
	assign o_p0_lvl = (i_p0_oe & i_p0_drv) | (~i_p0_oe & i_p0_ext);
	assign o_p1_lvl = (i_p1_oe & i_p1_drv) | (~i_p1_oe & i_p1_ext);
	// Port 2 only sinks, so an enabled bit pulls the line low.
	assign o_p2_lvl = ~i_p2_oe & i_p2_ext;
endmodule : pio_pins_model

/* File: pio_ports_bench.sv */
// Purpose: Self-checking bench for the three-port parallel I/O block.
// Assumes: Zero-wait APB slave; pins pass a four-edge input filter.
// Notes: Scenarios run in order and build on the state left before.
`timescale 1ns/1ps

module pio_ports_bench;
	import pio_pkg::*;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [PIO_ADDR_W-1:0] paddr = '0;
	logic [PIO_DATA_W-1:0] pwdata = '0;
	logic [PIO_DATA_W-1:0] prdata;
	logic [PIO_DATA_W-1:0] rd;
	logic pready, pslverr, irq, xtal, stop, err;
	logic [7:0] p0_drv, p0_oe, p0_lvl, p0_in, p1_drv, p1_oe, p1_lvl;
	logic [7:0] p0_per = 8'hFF;
	logic [7:0] p1_per = 8'hFF;
	logic [7:0] p1_ext = 8'h3C;
	logic [2:0] p2_oe, p2_lvl, p2_drv, p2_in;
	logic [7:0] p1_in;
	int miscompares = 0;
	int cmp_count = 0;

	pio_ports i_pio_ports (
		.i_mclk(mclk),
		.i_rstn(rstn),
		.i_psel(psel),
		.i_penable(penable),
		.i_pwrite(pwrite),
		.i_paddr(paddr),
		.i_pwdata(pwdata),
		.o_prdata(prdata),
		.o_pready(pready),
		.o_pslverr(pslverr),
		.i_p0_pin(p0_lvl),
		.o_p0_pin(p0_drv),
		.o_p0_pin_oe(p0_oe),
		.i_p0_periph_out(p0_per),
		.i_p1_pin(p1_lvl),
		.o_p1_pin(p1_drv),
		.o_p1_pin_oe(p1_oe),
		.i_p1_periph_out(p1_per),
		.i_p2_pin(p2_lvl),
		.o_p2_pin(p2_drv),
		.o_p2_pin_oe(p2_oe),
		.o_p0_in(p0_in),
		.o_p1_in(p1_in),
		.o_p2_in(p2_in),
		.o_slow_crystal_en(xtal),
		.o_stop_mode(stop),
		.o_irq(irq)
	);

	pio_pins_model i_pio_pins_model (
		.i_p0_drv(p0_drv),
		.i_p0_oe(p0_oe),
		.i_p0_ext(8'hFF),
		.i_p1_drv(p1_drv),
		.i_p1_oe(p1_oe),
		.i_p1_ext(p1_ext),
		.i_p2_oe(p2_oe),
		.i_p2_ext(3'h7),
		.o_p0_lvl(p0_lvl),
		.o_p1_lvl(p1_lvl),
		.o_p2_lvl(p2_lvl)
	);

	initial begin
		forever #4 mclk = ~mclk;
	end

	task automatic stop_test;
		$display("Compares %0d, errors %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Holds the request until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [5:0] idx,
		input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask : wr

	task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		chk(rd, exp);
	endtask : rdchk

	task automatic t_reset;
		repeat (6) @(posedge mclk);
		rdchk(PIO_IDX_P0_LATCH, 8'hFF);
		rdchk(PIO_IDX_P0_TYPE, 8'h00);
		rdchk(PIO_IDX_P1_DIR, 8'h00);
		rdchk(PIO_IDX_P1_LATCH, 8'h3C);
		rdchk(PIO_IDX_P2_LATCH, 8'h07);
		rdchk(PIO_IDX_IRQ_MASK, 8'h00);
		chk(p0_oe, 8'h00);
		chk(p1_oe, 8'h00);
		chk(irq, 1'b0);
	endtask : t_reset

	// Open drain first, as software must, then push-pull.
	task automatic t_port0;
		wr(PIO_IDX_P0_LATCH, 8'hA5);
		@(negedge mclk);
		chk(p0_oe, 8'h5A);
		rdchk(PIO_IDX_P0_LATCH, 8'hA5);
		wr(PIO_IDX_P0_TYPE, 8'hFF);
		@(negedge mclk);
		chk(p0_oe, 8'hFF);
		chk(p0_drv, 8'hA5);
		@(posedge mclk);
		p0_per <= 8'h0F;
		repeat (6) @(posedge mclk);
		chk(p0_drv, 8'h05);
		chk(p0_in, 8'h05);
		rdchk(PIO_IDX_P0_PINS, 8'h05);
		rdchk(PIO_IDX_P0_LATCH, 8'hA5);
		rdchk(PIO_IDX_IRQ_STAT, 8'h0C);
		p0_per <= 8'hFF;
		wr(PIO_IDX_P0_LATCH, 8'hFF);
		wr(PIO_IDX_P0_TYPE, 8'h00);
		@(negedge mclk);
		chk(p0_oe, 8'h00);
		repeat (6) @(posedge mclk);
		chk(p0_in, 8'hFF);
	endtask : t_port0

	task automatic t_port1;
		wr(PIO_IDX_P1_LATCH, 8'hFF);
		wr(PIO_IDX_P1_DIR, 8'hF0);
		@(negedge mclk);
		chk(p1_oe, 8'hF0);
		chk(p1_drv & p1_oe, 8'hF0);
		rdchk(PIO_IDX_P1_LATCH, 8'hFC);
		wr(PIO_IDX_P1_LATCH, rd);
		wr(PIO_IDX_P1_DIR, 8'hFF);
		rdchk(PIO_IDX_P1_LATCH, 8'hFC);
		chk(p1_in, 8'hFC);
	endtask : t_port1

	task automatic t_port2;
		wr(PIO_IDX_IRQ_STAT, 8'h1F);
		rdchk(PIO_IDX_IRQ_STAT, 8'h00);
		wr(PIO_IDX_P2_LATCH, 8'h06);
		@(negedge mclk);
		chk(p2_oe, 3'h1);
		repeat (6) @(posedge mclk);
		rdchk(PIO_IDX_P2_PINS, 8'h06);
		chk(p2_in, 3'h6);
		chk(p2_drv, 3'h0);
		rdchk(PIO_IDX_IRQ_STAT, 8'h01);
		chk(irq, 1'b0);
		wr(PIO_IDX_IRQ_MASK, 8'h01);
		@(negedge mclk);
		chk(irq, 1'b1);
		wr(PIO_IDX_IRQ_STAT, 8'h01);
		@(negedge mclk);
		chk(irq, 1'b0);
		wr(PIO_IDX_CTRL, 8'h03);
		@(negedge mclk);
		chk({xtal, stop, p2_oe[0]}, 3'h6);
	endtask : t_port2

	// Refused accesses must raise pslverr, and an unmapped read returns zero.
	task automatic t_errors;
		apb(1'b0, 6'h3F, 32'h0000_0000);
		chk(err, 1'b1);
		chk(rd, 32'h0000_0000);
		apb(1'b1, PIO_IDX_P0_PINS, 32'h0000_0000);
		chk(err, 1'b1);
		rdchk(PIO_IDX_P0_PINS, 8'hFF);
		chk(err, 1'b0);
	endtask : t_errors

	initial begin
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		t_reset;
		t_port0;
		t_port1;
		t_port2;
		t_errors;
		stop_test;
	end

	// Nearly forty times the span that the scenarios need.
	initial begin
		repeat (5000) @(posedge mclk);
		miscompares++;
		stop_test;
	end
endmodule : pio_ports_bench
